// ==== hw/main_control.v ====
// Contract
// (R1) jitter select 111 handles low and high frequency jitter, 000 low only.
// (R2) the jitter select field has no effect while discrimination is off.
// (R3) sample point low samples at 3/4 bit with delay in quarter bits 0..7 3/4.
// (R4) sample point high picks 3/4, 4/4, 1/4 or 2/4 plus 0..7 whole bits.
// (R5) software keeps reserved bit 11 at zero.
// (R6) the discriminator enable bit turns frame boundary discrimination on.
// (R7) local fast rate runs streams 0-15 at 32.768 Mbps, 16-31 unused.
// (R8) frame pulse width sets 122/122/61 ns or 244/244/122 ns pulses; the code uses 100/100/50 or 200/200/100 ns.
// (R9) backplane fast rate runs streams 0-15 at 32.768 Mbps, 16-31 unused.
// (R10) clock edge select low aligns the frame to the input clock fall.
// (R11) clock edge select high aligns the frame to the input clock rise.
`timescale 1ns/1ps
`include "main_control_regs.vh"

module main_control (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // microprocessor port
  input  wire        cs_n,
  input  wire        ds_n,
  input  wire        rd_wr_n,
  input  wire [14:0] addr,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_oe,
  output reg         dtack_n,
  // timing pins
  input  wire        input_clock,
  input  wire        frame_pulse_in,
  output reg         frame_pulse_out_8m,
  output reg         frame_pulse_out_16m,
  output reg         frame_align,
  // control to switch core
  output reg         discrim_active,
  output reg         jitter_high_mode,
  output reg         local_rate_32m,
  output reg         backplane_rate_32m,
  output reg  [31:0] local_stream_active,
  output reg  [31:0] backplane_stream_active,
  // per-stream delay decode
  input  wire [4:0]  stream_delay_code,
  output reg  [1:0]  sample_point,
  output reg  [2:0]  whole_bit_delay,
  output reg  [4:0]  quarter_delay
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ACK  = 2'h1;

  // widths in core cycles, cut to the width of the pulse counters
  localparam integer IN_N_CYC  = `NS_TO_CYC(`FP_IN_NARROW_NS);
  localparam integer IN_W_CYC  = `NS_TO_CYC(`FP_IN_WIDE_NS);
  localparam integer O8_N_CYC  = `NS_TO_CYC(`FP_8M_NARROW_NS);
  localparam integer O8_W_CYC  = `NS_TO_CYC(`FP_8M_WIDE_NS);
  localparam integer O16_N_CYC = `NS_TO_CYC(`FP_16M_NARROW_NS);
  localparam integer O16_W_CYC = `NS_TO_CYC(`FP_16M_WIDE_NS);
  localparam [2:0]   IN_W_N    = IN_N_CYC[2:0];
  localparam [2:0]   IN_W_W    = IN_W_CYC[2:0];
  localparam [2:0]   W8_N      = O8_N_CYC[2:0];
  localparam [2:0]   W8_W      = O8_W_CYC[2:0];
  localparam [2:0]   W16_N     = O16_N_CYC[2:0];
  localparam [2:0]   W16_W     = O16_W_CYC[2:0];

  // ********************
  // pin synchronisers
  // ********************
  reg  [2:0]  cs_s_r;
  reg  [2:0]  ds_s_r;
  reg  [2:0]  rw_s_r;
  reg  [2:0]  ck_s_r;
  reg  [2:0]  fp_s_r;
  reg  [14:0] addr_s1_r, addr_s2_r, addr_s3_r;
  reg  [15:0] din_s1_r,  din_s2_r,  din_s3_r;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      cs_s_r    <= 3'h7;
      ds_s_r    <= 3'h7;
      rw_s_r    <= 3'h7;
      ck_s_r    <= 3'h0;
      fp_s_r    <= 3'h0;
      addr_s1_r <= 15'h0000;
      addr_s2_r <= 15'h0000;
      addr_s3_r <= 15'h0000;
      din_s1_r  <= 16'h0000;
      din_s2_r  <= 16'h0000;
      din_s3_r  <= 16'h0000;
    end else begin
      cs_s_r    <= {cs_s_r[1:0], cs_n};
      ds_s_r    <= {ds_s_r[1:0], ds_n};
      rw_s_r    <= {rw_s_r[1:0], rd_wr_n};
      ck_s_r    <= {ck_s_r[1:0], input_clock};
      fp_s_r    <= {fp_s_r[1:0], frame_pulse_in};
      addr_s1_r <= addr;
      addr_s2_r <= addr_s1_r;
      addr_s3_r <= addr_s2_r;
      din_s1_r  <= data_in;
      din_s2_r  <= din_s1_r;
      din_s3_r  <= din_s2_r;
    end
  end

  // a level counts only once stages two and three agree
  reg         cs_lvl_r, ds_lvl_r, ck_lvl_r, fp_lvl_r;
  wire        ck_prev = ck_lvl_r;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      cs_lvl_r <= 1'b1;
      ds_lvl_r <= 1'b1;
      ck_lvl_r <= 1'b0;
      fp_lvl_r <= 1'b0;
    end else begin
      if (cs_s_r[1] == cs_s_r[2])
        cs_lvl_r <= cs_s_r[2];
      if (ds_s_r[1] == ds_s_r[2])
        ds_lvl_r <= ds_s_r[2];
      if (ck_s_r[1] == ck_s_r[2])
        ck_lvl_r <= ck_s_r[2];
      if (fp_s_r[1] == fp_s_r[2])
        fp_lvl_r <= fp_s_r[2];
    end
  end

  wire ck_next = (ck_s_r[1] == ck_s_r[2]) ? ck_s_r[2] : ck_lvl_r;

  // ********************
  // register access
  // ********************
  reg  [1:0]  state_r;
  reg  [15:0] main_control_r;
  wire        hit = (addr_s3_r == `MAIN_CONTROL_ADDR);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_r        <= ST_IDLE;
      main_control_r <= `MAIN_CONTROL_RESET;
      data_out       <= 16'h0000;
      data_oe        <= 1'b0;
      dtack_n        <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!cs_lvl_r && !ds_lvl_r) begin
            state_r <= ST_ACK;
            dtack_n <= 1'b0;
            if (rw_s_r[2]) begin
              data_oe  <= 1'b1;
              // unmapped addresses read as zero
              data_out <= hit ? main_control_r : 16'h0000;
            end else if (hit) begin
              // (R5) reserved kept as written
              main_control_r <= din_s3_r;
            end
          end
        end
        ST_ACK: begin
          if (ds_lvl_r || cs_lvl_r) begin
            state_r <= ST_IDLE;
            dtack_n <= 1'b1;
            data_oe <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          dtack_n <= 1'b1;
          data_oe <= 1'b0;
        end
      endcase
    end
  end

  wire [2:0] jit_sel = main_control_r[`JITTER_SEL_HI:`JITTER_SEL_LO];
  wire       disc_on = main_control_r[`DISCRIM_ON_BIT];
  wire       smpl_hi = main_control_r[`SAMPLE_POINT_BIT];
  wire       loc_32  = main_control_r[`LOCAL_FAST_BIT];
  wire       bp_32   = main_control_r[`BACKPLANE_FAST_BIT];
  wire       fp_wide = main_control_r[`FRAME_WIDE_BIT];
  wire       edge_hi = main_control_r[`CLOCK_EDGE_BIT];

  // ********************
  // mode decode
  // ********************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      discrim_active          <= 1'b0;
      jitter_high_mode        <= 1'b0;
      local_rate_32m          <= 1'b0;
      backplane_rate_32m      <= 1'b0;
      local_stream_active     <= `ALL_STREAM_MASK;
      backplane_stream_active <= `ALL_STREAM_MASK;
      sample_point            <= `POINT_3Q;
      whole_bit_delay         <= 3'h0;
      quarter_delay           <= 5'h00;
    end else begin
      // (R6) discriminator enable
      discrim_active <= disc_on;
      // (R1) (R2) mode only when enabled
      // reserved codes fall back to low-frequency handling
      jitter_high_mode <= disc_on && (jit_sel == `JITTER_BOTH);
      // (R7) local stream allocation
      local_rate_32m      <= loc_32;
      local_stream_active <= loc_32 ? `FAST_STREAM_MASK
                                    : `ALL_STREAM_MASK;
      // (R9) backplane stream allocation
      backplane_rate_32m      <= bp_32;
      backplane_stream_active <= bp_32 ? `FAST_STREAM_MASK
                                       : `ALL_STREAM_MASK;
      if (smpl_hi) begin
        // (R4) point plus whole bits
        sample_point    <= stream_delay_code[1:0];
        whole_bit_delay <= stream_delay_code[4:2];
        quarter_delay   <= {stream_delay_code[4:2], 2'h0};
      end else begin
        // (R3) fixed 3/4, quarter steps
        sample_point    <= `POINT_3Q;
        whole_bit_delay <= stream_delay_code[4:2];
        quarter_delay   <= stream_delay_code;
      end
    end
  end

  // ********************
  // frame alignment
  // ********************
  // pulse width is counted in core cycles and checked on the selected clock edge only, so a
  // wrong width setting shows as a missed alignment, not a double one
  reg  [2:0] fp_len_r;
  reg  [2:0] cnt8_r;
  reg  [2:0] cnt16_r;
  wire       rise   = ck_next && !ck_prev;
  wire       fall   = !ck_next && ck_prev;
  // (R10) (R11) edge select
  wire       sel_ed = edge_hi ? rise : fall;
  wire [2:0] need   = fp_wide ? IN_W_W : IN_W_N;
  // one spare bit so a saturated length never wraps below the limit
  wire       take   = sel_ed && fp_lvl_r &&
                      ({1'h0, fp_len_r} + 4'h1 >= {1'h0, need});

  always @(posedge core_clk) begin
    if (!rst_n) begin
      fp_len_r            <= 3'h0;
      cnt8_r              <= 3'h0;
      cnt16_r             <= 3'h0;
      frame_align         <= 1'b0;
      frame_pulse_out_8m  <= 1'b0;
      frame_pulse_out_16m <= 1'b0;
    end else begin
      frame_align <= 1'b0;
      if (fp_lvl_r) begin
        if (fp_len_r != 3'h7)
          fp_len_r <= fp_len_r + 3'h1;
      end else begin
        fp_len_r <= 3'h0;
      end
      // (R8) widths follow frame pulse wide
      if (take) begin
        frame_align <= 1'b1;
        cnt8_r      <= fp_wide ? W8_W : W8_N;
        cnt16_r     <= fp_wide ? W16_W : W16_N;
      end else begin
        if (cnt8_r != 3'h0)
          cnt8_r <= cnt8_r - 3'h1;
        if (cnt16_r != 3'h0)
          cnt16_r <= cnt16_r - 3'h1;
      end
      frame_pulse_out_8m  <= (cnt8_r > 3'h1) || take;
      frame_pulse_out_16m <= (cnt16_r > 3'h1) || take;
    end
  end

endmodule

// ==== hw/main_control_regs.vh ====
`ifndef MAIN_CONTROL_REGS_VH
`define MAIN_CONTROL_REGS_VH

// ********************
// register map
// ********************
`define MAIN_CONTROL_ADDR      15'h0000
`define MAIN_CONTROL_RESET     16'h0000

// ********************
// field positions
// ********************
`define JITTER_SEL_HI          15
`define JITTER_SEL_LO          13
`define SAMPLE_POINT_BIT       12
`define RESERVED_BIT           11
`define DISCRIM_ON_BIT         10
`define LOCAL_FAST_BIT         9
`define FRAME_WIDE_BIT         8
`define BACKPLANE_FAST_BIT     7
`define CLOCK_EDGE_BIT         6

// ********************
// field codes
// ********************
`define JITTER_BOTH            3'h7
`define JITTER_LOW_ONLY        3'h0
`define POINT_3Q               2'h0
`define FAST_STREAM_MASK       32'h0000FFFF
`define ALL_STREAM_MASK        32'hFFFFFFFF

// ********************
// timing
// ********************
`define CLK_MHZ                20
`define FP_IN_NARROW_NS        122
`define FP_8M_NARROW_NS        122
`define FP_16M_NARROW_NS       61
`define FP_IN_WIDE_NS          244
`define FP_8M_WIDE_NS          244
`define FP_16M_WIDE_NS         122
`define NS_TO_CYC(ns)          (((ns) * `CLK_MHZ / 1000) < 1 ? 1 : \
                                ((ns) * `CLK_MHZ / 1000))

`endif

// ==== verif/main_control_monitor.sv ====
`timescale 1ns/1ps
// ****
// checker
// ****
module main_control_monitor (
  input wire        core_clk,
  input wire        rst_n,
  input wire        dtack_n,
  input wire        frame_align,
  input wire        frame_pulse_out_8m,
  input wire        frame_pulse_out_16m,
  input wire        discrim_active,
  input wire        jitter_high_mode,
  input wire        local_rate_32m,
  input wire        backplane_rate_32m,
  input wire [31:0] local_stream_active,
  input wire [31:0] backplane_stream_active,
  input wire [1:0]  sample_point,
  input wire [2:0]  whole_bit_delay,
  input wire [4:0]  quarter_delay
);
  wire f8  = frame_pulse_out_8m;
  wire f16 = frame_pulse_out_16m;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // the 16m pulse is half as long as the 8m one
  sequence s_narrow;
    (f8 && f16) ##1 (f8 && !f16) ##1 !f8;
  endsequence
  sequence s_wide;
    (f8 && f16) [*2] ##1 (f8 && !f16) [*2] ##1 !f8;
  endsequence
  a_frame_shape: assert property (
    frame_align |-> s_narrow or s_wide) else $error("frame pulse shape");
  a_jitter_needs_on: assert property (
    jitter_high_mode |-> discrim_active) else $error("jitter while off");
  a_local_mask: assert property (
    local_stream_active == (local_rate_32m ? 32'h0000FFFF : 32'hFFFFFFFF))
    else $error("local mask");
  a_bp_mask: assert property (
    backplane_stream_active ==
    (backplane_rate_32m ? 32'h0000FFFF : 32'hFFFFFFFF))
    else $error("backplane mask");
  a_whole_bits: assert property (
    quarter_delay[4:2] == whole_bit_delay) else $error("whole bits");
  a_point_whole: assert property (
    sample_point != 2'h0 |-> quarter_delay[1:0] == 2'h0)
    else $error("point with fraction");
  // discrim_active and jitter_high_mode may only move while an access is acknowledged
  a_discrim_write: assert property (
    $changed(discrim_active) |-> !dtack_n || $past(!dtack_n))
    else $error("discrim moved without access");
  a_jitter_write: assert property (
    $changed(jitter_high_mode) |-> !dtack_n || $past(!dtack_n))
    else $error("jitter moved without access");
endmodule

bind main_control main_control_monitor main_control_monitor_i (
  .core_clk, .rst_n, .dtack_n, .frame_align, .frame_pulse_out_8m,
  .frame_pulse_out_16m, .discrim_active, .jitter_high_mode,
  .local_rate_32m, .backplane_rate_32m, .local_stream_active,
  .backplane_stream_active, .sample_point, .whole_bit_delay,
  .quarter_delay);

// ==== verif/main_control_tb_top.sv ====
`timescale 1ns/1ps
// ****
// testbench
// ****
module main_control_tb_top;
  logic        core_clk, rst_n, cs_n, ds_n, rd_wr_n;
  logic        input_clock, frame_pulse_in;
  logic [14:0] addr;
  logic [15:0] data_in, q;
  logic [4:0]  stream_delay_code;
  wire  [15:0] data_out;
  wire         data_oe, dtack_n, frame_pulse_out_8m, frame_pulse_out_16m;
  wire         frame_align, discrim_active, jitter_high_mode;
  wire         local_rate_32m, backplane_rate_32m;
  wire  [31:0] local_stream_active, backplane_stream_active;
  wire  [1:0]  sample_point;
  wire  [2:0]  whole_bit_delay;
  wire  [4:0]  quarter_delay;
  int          n_mismatch, checks;

  main_control main_control_i (
    .core_clk                (core_clk),
    .rst_n                   (rst_n),
    .cs_n                    (cs_n),
    .ds_n                    (ds_n),
    .rd_wr_n                 (rd_wr_n),
    .addr                    (addr),
    .data_in                 (data_in),
    .data_out                (data_out),
    .data_oe                 (data_oe),
    .dtack_n                 (dtack_n),
    .input_clock             (input_clock),
    .frame_pulse_in          (frame_pulse_in),
    .frame_pulse_out_8m      (frame_pulse_out_8m),
    .frame_pulse_out_16m     (frame_pulse_out_16m),
    .frame_align             (frame_align),
    .discrim_active          (discrim_active),
    .jitter_high_mode        (jitter_high_mode),
    .local_rate_32m          (local_rate_32m),
    .backplane_rate_32m      (backplane_rate_32m),
    .local_stream_active     (local_stream_active),
    .backplane_stream_active (backplane_stream_active),
    .stream_delay_code       (stream_delay_code),
    .sample_point            (sample_point),
    .whole_bit_delay         (whole_bit_delay),
    .quarter_delay           (quarter_delay)
  );

  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // strobes held until the acknowledge is seen settled, then released;
  // outputs are looked at on the falling edge, never in the launch step
  task automatic acc(input logic wr, input logic [14:0] a,
                     input logic [15:0] d);
    int i;
    int j;
    @(negedge core_clk);
    cs_n = 1'h0;
    ds_n = 1'h0;
    rd_wr_n = !wr;
    addr = a;
    data_in = d;
    i = 0;
    while (i < 20 && dtack_n !== 1'h0) begin
      @(negedge core_clk);
      i++;
    end
    q = data_out;
    if (i < 20)
      chk(data_oe, !wr, "bus drive");
    cs_n = 1'h1;
    ds_n = 1'h1;
    j = 0;
    while (j < 20 && dtack_n !== 1'h1) begin
      @(negedge core_clk);
      j++;
    end
    chk(data_oe, 1'h0, "bus released");
    if (i >= 20 || j >= 20) begin
      $display("[ERR] %0t access timeout", $time);
      n_mismatch++;
      results();
    end
  endtask

  task automatic t_reset;
    chk(dtack_n, 1'h1, "reset ack");
    chk(data_oe, 1'h0, "reset drive");
    chk(local_stream_active, 32'hFFFFFFFF, "reset local mask");
    chk(backplane_stream_active, 32'hFFFFFFFF, "reset bp mask");
    chk(frame_pulse_out_8m, 1'h0, "reset 8m");
    chk(frame_pulse_out_16m, 1'h0, "reset 16m");
    acc(1'h0, 15'h0000, 16'h0000);
    chk(q, 16'h0000, "reset value");
    acc(1'h1, 15'h0001, 16'hFFFF);
    acc(1'h0, 15'h0001, 16'h0000);
    chk(q, 16'h0000, "unmapped read");
    acc(1'h0, 15'h0000, 16'h0000);
    chk(q, 16'h0000, "unmapped write leaked");
    $display("t_reset done");
  endtask

  task automatic t_rates;
    acc(1'h1, 15'h0000, 16'h0280);
    chk(local_stream_active, 32'h0000FFFF, "local mask");
    chk(backplane_stream_active, 32'h0000FFFF, "bp mask");
    chk(local_rate_32m, 1'h1, "local rate");
    acc(1'h1, 15'h0000, 16'h0080);
    chk(local_rate_32m, 1'h0, "local rate off");
    chk(local_stream_active, 32'hFFFFFFFF, "local mask");
    chk(backplane_rate_32m, 1'h1, "bp rate");
    $display("t_rates done");
  endtask

  task automatic t_jitter;
    logic [15:0] v;
    for (int c = 0; c < 16; c++) begin
      v = {c[2:0], 2'h0, c[3], 10'h000};
      acc(1'h1, 15'h0000, v);
      acc(1'h0, 15'h0000, 16'h0000);
      chk(q, v, "readback");
      chk(discrim_active, c[3], "discrim");
      chk(jitter_high_mode, c[3:0] == 4'hF, "jitter");
    end
    $display("t_jitter done");
  endtask

  task automatic t_delay;
    for (int m = 0; m < 2; m++) begin
      acc(1'h1, 15'h0000, {3'h0, m[0], 12'h000});
      for (int c = 0; c < 32; c++) begin
        stream_delay_code = c[4:0];
        @(negedge core_clk);
        chk(sample_point, m ? c[1:0] : 2'h0, "point");
        chk(quarter_delay, m ? {c[4:2], 2'h0} : c[4:0], "qtr");
        chk(whole_bit_delay, c[4:2], "whole");
      end
    end
    $display("t_delay done");
  endtask

  // k[0] edge select, k[1] wide pulse, k[2] clock makes the other edge
  task automatic t_frame;
    int n8, n16, na;
    for (int k = 0; k < 8; k++) begin
      input_clock = !(k[0] ^ k[2]);
      acc(1'h1, 15'h0000, {7'h00, k[1], 1'h0, k[0], 6'h00});
      n8 = 0;
      n16 = 0;
      na = 0;
      for (int t = 0; t < 20; t++) begin
        @(negedge core_clk);
        frame_pulse_in = t < (k[1] ? 5 : 3);
        if (t == (k[1] ? 4 : 2))
          input_clock = k[0] ^ k[2];
        n8 += frame_pulse_out_8m;
        n16 += frame_pulse_out_16m;
        na += frame_align;
      end
      chk(na, k[2] ? 0 : 1, "align count");
      chk(n8, k[2] ? 0 : (k[1] ? 4 : 2), "8m width");
      chk(n16, k[2] ? 0 : (k[1] ? 2 : 1), "16m width");
    end
    $display("t_frame done");
  endtask

  initial begin
    rst_n = 1'h0;
    cs_n = 1'h1;
    ds_n = 1'h1;
    rd_wr_n = 1'h1;
    addr = 15'h0000;
    data_in = 16'h0000;
    input_clock = 1'h0;
    frame_pulse_in = 1'h0;
    stream_delay_code = 5'h00;
    repeat (2) @(negedge core_clk);
    rst_n = 1'h1;
    t_reset;
    t_rates;
    t_jitter;
    t_delay;
    t_frame;
    results;
  end
endmodule
